// ### logic/dcc_pkg.sv
// shared constants for the conversion clock and control block
package dcc_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int unsigned REG_RESULT_LO  = 0;
    localparam int unsigned REG_RESULT_HI  = 1;
    localparam int unsigned REG_FAULT      = 2;
    localparam int unsigned REG_ADC_CTRL   = 3;
    localparam int unsigned REG_GAIN_MUX   = 4;
    localparam int unsigned REG_CMD        = 6;
    localparam int unsigned REG_REF_OSC    = 7;
    localparam int unsigned ADDR_W         = 5;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned RLO_CLIP_BIT   = 0;
    localparam int unsigned CTRL_LSBF_BIT  = 0;
    localparam int unsigned CTRL_DIV_LSB   = 4;
    localparam int unsigned GM_CNV_BIT     = 7;
    localparam int unsigned GM_GAIN_LSB    = 4;
    localparam int unsigned GM_SWAP_BIT    = 2;
    localparam int unsigned GM_DIFF_BIT    = 3;
    localparam int unsigned CMD_RST_BIT    = 0;
    localparam int unsigned RO_SRC_BIT     = 5;
    localparam int unsigned RO_OSC_BIT     = 4;
    localparam int unsigned RO_REF_BIT     = 3;
    localparam int unsigned RO_BUFE_BIT    = 2;

    // ------------------------------------------------------------
    // reset values and encodings
    // ------------------------------------------------------------
    localparam logic [7:0] REG_RESET       = 8'h00;
    localparam logic [1:0] REF_2V5         = 2'h0;
    localparam logic [1:0] REF_2V048       = 2'h1;
    localparam logic [1:0] REF_1V15        = 2'h2;
    localparam logic [2:0] GAIN_X1         = 3'h0;
    localparam logic [13:0] CODE_POS_MAX   = 14'h1fff;
    localparam logic [13:0] CODE_NEG_MIN   = 14'h2000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned MCLK_KHZ       = 125000;
    localparam int unsigned OSC_KHZ        = 2500;
    localparam int unsigned OSC_HALF_CYC   = MCLK_KHZ / (2 * OSC_KHZ);
    localparam int unsigned ACQ_TICKS      = 36;
    localparam int unsigned SAR_TICKS      = 14;
    localparam int unsigned CNV_TICKS      = ACQ_TICKS + SAR_TICKS;

    typedef enum logic [1:0] {
        CNV_IDLE,
        CNV_ACQ,
        CNV_SAR
    } dcc_cnv_state_t;

endpackage

// ### logic/dcc_clk_div.sv
// divides conversion clock edges into divided conversion clock ticks
`timescale 1ns/10ps
`default_nettype none
module dcc_clk_div (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       srst,
    // control
    input  wire logic       restart,
    input  wire logic [1:0] division_factor,
    // edges in, ticks out
    input  wire logic       pclk_edge,
    output logic            div_tick
);
    logic [2:0] count;
    logic [2:0] limit;

    // ------------------------------------------------------------
    // factor 1, 2, 4 or 8
    // ------------------------------------------------------------
    assign limit     = 3'((4'h1 << division_factor) - 4'h1);
    assign div_tick  = pclk_edge && (count == limit);

    always_ff @(posedge mclk) begin
        if (srst || restart) begin
            count <= 3'h0;
        end else if (pclk_edge) begin
            count <= (count == limit) ? 3'h0 : count + 3'h1;
        end
    end
endmodule
`default_nettype wire

// ### logic/dcc_ctrl.sv
// conversion clock, configuration and result control of the acquisition device
//
// How it works
// - pin or bit drives clock pin from oscillator
// - source and reference bits feed reference from oscillator
// - divide conversion clock by 1, 2, 4, 8
// - host port timing independent of conversion clock
// - clock sensed back at pin both directions
// - amplifier, converter bias only during conversion
// - disabled reference buffer output goes high-Z
// - reference select 1.15/2.048/2.5 V, 2.5 default
// - three-bit gain field in register 4
// - four-bit channel field configures eight inputs
// - swap bit inverts differential result sign
// - result bit 0 is OR of faults
// - register 2 records individual faults
// - two's complement result, msb or lsb first
// - differential codes span -8192 to 8191
// - single-ended codes span 0 to 8191
// - low result bit D1 zero; 14 SAR clocks
// - gain codes 000-111 map in order, default 1
// - master reset clears every register
// - oscillator, start, reset are pin OR bit
// - conversion is 36 plus 14 divided clocks
//
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module dcc_ctrl
    import dcc_pkg::*;
#(
    parameter int unsigned FAULT_W = 8
) (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               srst,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0]  avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic [31:0]             avs_readdata,
    output logic [1:0]              avs_response,
    output logic                    avs_waitrequest,
    // device pins
    input  wire logic               reset_pin,
    input  wire logic               convert_pin,
    input  wire logic               oscillator_request_pin,
    input  wire logic               conversion_clock_i,
    output logic                    conversion_clock_o,
    output logic                    conversion_clock_oe,
    // analog front end
    input  wire logic [FAULT_W-1:0] fault_detect,
    input  wire logic [13:0]        sar_code,
    output logic [3:0]              analog_inputs_sel,
    output logic [2:0]              amplifier_gain_field,
    output logic                    amp_bias_en,
    output logic                    adc_bias_en,
    output logic                    sar_phase,
    output logic                    busy,
    // reference
    output logic                    osc_run,
    output logic                    ref_clk_from_osc,
    output logic                    ref_en,
    output logic [1:0]              ref_voltage_sel,
    output logic                    reference_buffer_oe
);
    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    logic [7:0]         reg_result_lo, reg_result_hi, reg_fault;
    logic [7:0]         reg_adc_ctrl, reg_gain_mux, reg_ref_osc;
    logic [1:0]         rst_s, cnv_s, oreq_s, pclk_s;
    logic [FAULT_W-1:0] flt_s1, flt_s2, flt_acc;
    logic [13:0]        code_s1, code_s2;
    logic               pclk_d, cnv_d, cnv_pend;
    logic [5:0]         tick_cnt;
    logic [7:0]         osc_cnt;
    logic               osc_clk;
    dcc_cnv_state_t     state, next_state;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire                hit_wr    = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire [7:0]          wbyte     = avs_writedata[7:0];
    wire                wr_ctrl   = hit_wr && (avs_address == ADDR_W'(REG_ADC_CTRL));
    wire                wr_gm     = hit_wr && (avs_address == ADDR_W'(REG_GAIN_MUX));
    wire                wr_cmd    = hit_wr && (avs_address == ADDR_W'(REG_CMD));
    wire                wr_ro     = hit_wr && (avs_address == ADDR_W'(REG_REF_OSC));
    wire                soft_rst  = wr_cmd && wbyte[CMD_RST_BIT];
    wire                dev_rst   = srst || rst_s[1] || soft_rst;
    wire                osc_bit   = reg_ref_osc[RO_OSC_BIT];
    wire                pin_drive = oreq_s[1] || osc_bit;
    wire                ref_osc   = reg_ref_osc[RO_SRC_BIT] && reg_ref_osc[RO_REF_BIT];
    wire                pclk_edge = pclk_s[1] && !pclk_d;
    wire                cnv_rise  = cnv_s[1] && !cnv_d;
    wire                cnv_req   = cnv_rise || (wr_gm && wbyte[GM_CNV_BIT]);
    wire [1:0]          dsel      = reg_adc_ctrl[CTRL_DIV_LSB +: 2];
    wire                dsel_wr   = wr_ctrl && (wbyte[CTRL_DIV_LSB +: 2] != dsel);
    wire                div_tick;
    wire                acq_done  = (state == CNV_ACQ) && div_tick
                                    && (tick_cnt == 6'(ACQ_TICKS - 1));
    wire                sar_done  = (state == CNV_SAR) && div_tick
                                    && (tick_cnt == 6'(CNV_TICKS - 1));
    wire                diff_sel  = reg_gain_mux[GM_DIFF_BIT];
    wire                swap_sel  = diff_sel && reg_gain_mux[GM_SWAP_BIT];

    // ------------------------------------------------------------
    // result coding
    // ------------------------------------------------------------
    wire [13:0]         neg_code  = (code_s2 == CODE_NEG_MIN) ? CODE_POS_MAX
                                    : 14'(~code_s2 + 14'h1);
    wire [13:0]         diff_code = swap_sel ? neg_code : code_s2;
    wire [13:0]         se_code   = code_s2[13] ? 14'h0000 : code_s2;
    wire [13:0]         res_code  = diff_sel ? diff_code : se_code;
    wire                lsb_first = reg_adc_ctrl[CTRL_LSBF_BIT];
    wire [13:0]         code_rev  = {<<{res_code}};
    wire [13:0]         out_code  = lsb_first ? code_rev : res_code;
    wire                clip      = |(flt_acc | flt_s2);
    wire [7:0]          next_lo   = {out_code[5:0], 1'b0, clip};

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [7:0]         rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        unique case (avs_address)
            ADDR_W'(REG_RESULT_LO): rd_byte = reg_result_lo;
            ADDR_W'(REG_RESULT_HI): rd_byte = reg_result_hi;
            ADDR_W'(REG_FAULT):     rd_byte = reg_fault;
            ADDR_W'(REG_ADC_CTRL):  rd_byte = reg_adc_ctrl;
            ADDR_W'(REG_GAIN_MUX):  rd_byte = reg_gain_mux;
            ADDR_W'(REG_REF_OSC):   rd_byte = reg_ref_osc;
            default:                rd_byte = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // bus handshake: one wait cycle, then the answer
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
            avs_response    <= 2'h0;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            rst_s   <= 2'h0;
            cnv_s   <= 2'h0;
            oreq_s  <= 2'h0;
            pclk_s  <= 2'h0;
            pclk_d  <= 1'b0;
            cnv_d   <= 1'b0;
            flt_s1  <= '0;
            flt_s2  <= '0;
            code_s1 <= 14'h0000;
            code_s2 <= 14'h0000;
        end else begin
            rst_s   <= {rst_s[0], reset_pin};
            cnv_s   <= {cnv_s[0], convert_pin};
            oreq_s  <= {oreq_s[0], oscillator_request_pin};
            pclk_s  <= {pclk_s[0], conversion_clock_i};
            pclk_d  <= pclk_s[1];
            cnv_d   <= cnv_s[1];
            flt_s1  <= fault_detect;
            flt_s2  <= flt_s1;
            code_s1 <= sar_code;
            code_s2 <= code_s1;
        end
    end

    // ------------------------------------------------------------
    // internal oscillator from a divider of mclk
    // ------------------------------------------------------------
    // runs only when something needs it, to save power
    wire                osc_need = pin_drive || ref_osc;
    always_ff @(posedge mclk) begin
        if (dev_rst || !osc_need) begin
            osc_cnt <= 8'h00;
            osc_clk <= 1'b0;
        end else if (osc_cnt == 8'(OSC_HALF_CYC - 1)) begin
            osc_cnt <= 8'h00;
            osc_clk <= !osc_clk;
        end else begin
            osc_cnt <= osc_cnt + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            reg_adc_ctrl <= REG_RESET;
            reg_gain_mux <= REG_RESET;
            reg_ref_osc  <= REG_RESET;
        end else begin
            if (wr_ctrl) begin
                reg_adc_ctrl <= wbyte & 8'h31;
            end
            if (wr_gm) begin
                reg_gain_mux <= {1'b0, wbyte[6:0]};
            end
            if (wr_ro) begin
                reg_ref_osc <= {2'b00, wbyte[5:2],
                                (wbyte[1:0] == 2'h3) ? REF_2V5 : wbyte[1:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // divided conversion clock
    // ------------------------------------------------------------
    dcc_clk_div u_div (
        .mclk            (mclk),
        .srst            (dev_rst),
        .restart         (dsel_wr),
        .division_factor (dsel),
        .pclk_edge       (pclk_edge),
        .div_tick        (div_tick)
    );

    // ------------------------------------------------------------
    // conversion sequence
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            CNV_IDLE: if (cnv_pend && div_tick) next_state = CNV_ACQ;
            CNV_ACQ:  if (acq_done) next_state = CNV_SAR;
            CNV_SAR:  if (sar_done) next_state = CNV_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            state    <= CNV_IDLE;
            tick_cnt <= 6'h00;
            cnv_pend <= 1'b0;
            flt_acc  <= '0;
        end else begin
            state    <= next_state;
            // a new request while busy queues behind the running one
            if (cnv_req) begin
                cnv_pend <= 1'b1;
            end else if (state == CNV_IDLE && div_tick) begin
                cnv_pend <= 1'b0;
            end
            if (state == CNV_IDLE) begin
                tick_cnt <= 6'h00;
                flt_acc  <= '0;
            end else begin
                flt_acc  <= flt_acc | flt_s2;
                if (div_tick) begin
                    tick_cnt <= tick_cnt + 6'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // result registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            reg_result_lo <= REG_RESET;
            reg_result_hi <= REG_RESET;
            reg_fault     <= REG_RESET;
        end else if (sar_done) begin
            reg_result_lo <= next_lo;
            reg_result_hi <= out_code[13:6];
            reg_fault     <= 8'(flt_acc | flt_s2);
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            conversion_clock_o  <= 1'b0;
            conversion_clock_oe <= 1'b0;
            analog_inputs_sel   <= 4'h0;
            amplifier_gain_field <= GAIN_X1;
            amp_bias_en         <= 1'b0;
            adc_bias_en         <= 1'b0;
            sar_phase           <= 1'b0;
            busy                <= 1'b0;
            osc_run             <= 1'b0;
            ref_clk_from_osc    <= 1'b0;
            ref_en              <= 1'b0;
            ref_voltage_sel     <= REF_2V5;
            reference_buffer_oe <= 1'b0;
        end else begin
            conversion_clock_o  <= osc_clk;
            conversion_clock_oe <= pin_drive;
            analog_inputs_sel   <= reg_gain_mux[3:0];
            amplifier_gain_field <= reg_gain_mux[GM_GAIN_LSB +: 3];
            amp_bias_en         <= (next_state != CNV_IDLE);
            adc_bias_en         <= (next_state == CNV_SAR);
            sar_phase           <= (next_state == CNV_SAR);
            busy                <= (next_state != CNV_IDLE) || cnv_pend;
            osc_run             <= osc_need;
            ref_clk_from_osc    <= ref_osc;
            ref_en              <= reg_ref_osc[RO_REF_BIT];
            ref_voltage_sel     <= reg_ref_osc[1:0];
            reference_buffer_oe <= reg_ref_osc[RO_BUFE_BIT];
        end
    end
endmodule
`default_nettype wire

// ### test/dcc_clk_source.sv
// board clock source sharing the conversion clock pin
`timescale 1ns/10ps
`default_nettype none
module dcc_clk_source (
    // device side of the pin
    input  wire logic drv_o,
    input  wire logic drv_oe,
    // level at the pin
    output logic      pin
);
    // ------------------------------------------------
    // free-running board clock
    // ------------------------------------------------
    // 406 ns period keeps the divided clock under the upper limit even at divide by one
    logic ext = 1'b0;
    always #203 ext = ~ext;
    // board clock backs off while the device drives the pin
    assign pin = drv_oe ? drv_o : ext;
endmodule
`default_nettype wire

// ### test/dcc_ctrl_assertions.sv
// concurrent checks on the control block's ports
`timescale 1ns/10ps
`default_nettype none
module dcc_chk (
    // clock and reset
    input wire logic       mclk,
    input wire logic       srst,
    // bus and pins
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic [1:0] avs_response,
    input wire logic       avs_waitrequest,
    input wire logic       oscillator_request_pin,
    input wire logic       conversion_clock_o,
    input wire logic       conversion_clock_oe,
    input wire logic       osc_run,
    input wire logic       ref_clk_from_osc,
    input wire logic       ref_en,
    input wire logic       amp_bias_en,
    input wire logic       adc_bias_en,
    input wire logic       sar_phase,
    input wire logic       busy
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    // ------------------------------------------------
    // register bus
    // ------------------------------------------------
    a_wait_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered next cycle");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_wait_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
        else $error("answer without request");
    a_resp_okay: assert property (avs_response == 2'h0)
        else $error("bus response not okay");
    // ------------------------------------------------
    // clock, reference and conversion
    // ------------------------------------------------
    a_osc_request: assert property (oscillator_request_pin |-> ##[0:6] conversion_clock_oe)
        else $error("pin request did not drive clock pin");
    a_oe_osc: assert property (conversion_clock_oe |-> osc_run)
        else $error("clock pin driven without oscillator");
    a_osc_period: assert property (
        $changed(conversion_clock_o) && osc_run
        |=> (!osc_run || $stable(conversion_clock_o)) [*8])
        else $error("oscillator faster than expected");
    a_ref_from_osc: assert property (ref_clk_from_osc |-> ref_en)
        else $error("reference clock source without reference");
    a_adc_sar: assert property (adc_bias_en == sar_phase)
        else $error("converter bias outside approximation phase");
    a_sar_in_conv: assert property (sar_phase |-> amp_bias_en && busy)
        else $error("approximation outside conversion");
    a_amp_busy: assert property (amp_bias_en |-> busy)
        else $error("amplifier bias while idle");
    a_busy_holds: assert property ($rose(busy) |=> busy [*8])
        else $error("conversion ended too soon");
endmodule
bind dcc_ctrl dcc_chk u_chk (.mclk, .srst, .avs_read, .avs_write, .avs_response,
    .avs_waitrequest, .oscillator_request_pin, .conversion_clock_o, .conversion_clock_oe,
    .osc_run, .ref_clk_from_osc, .ref_en, .amp_bias_en, .adc_bias_en, .sar_phase, .busy);
`default_nettype wire

// ### test/dcc_ctrl_test.sv
// self-checking bench for the conversion clock and control block
`timescale 1ns/10ps
`default_nettype none
module dcc_ctrl_test
    import dcc_pkg::*;
;
    logic mclk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic reset_pin = 1'b0, convert_pin = 1'b0, oscillator_request_pin = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata;
    logic [3:0]  avs_byteenable = 4'h1, analog_inputs_sel;
    logic [7:0]  fault_detect = '0;
    logic [13:0] sar_code = '0;
    logic [2:0]  amplifier_gain_field;
    logic [1:0]  avs_response, ref_voltage_sel;
    logic avs_waitrequest, conversion_clock_i, conversion_clock_o, conversion_clock_oe;
    logic amp_bias_en, adc_bias_en, sar_phase, busy, osc_run, ref_clk_from_osc, ref_en;
    logic reference_buffer_oe;
    logic [7:0] mdl [0:7] = '{default: 8'h00};
    int n_errors = 0, total_checks = 0, seed = 90643, n_edges = 0;
    always #4 mclk = ~mclk;
    always @(posedge conversion_clock_i) if (busy === 1'b1) n_edges++;
    dcc_ctrl #(.FAULT_W(8)) u_dut (.mclk, .srst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_response, .avs_waitrequest,
        .reset_pin, .convert_pin, .oscillator_request_pin, .conversion_clock_i,
        .conversion_clock_o, .conversion_clock_oe, .fault_detect, .sar_code,
        .analog_inputs_sel, .amplifier_gain_field, .amp_bias_en, .adc_bias_en, .sar_phase,
        .busy, .osc_run, .ref_clk_from_osc, .ref_en, .ref_voltage_sel, .reference_buffer_oe);
    dcc_clk_source u_clk (.drv_o(conversion_clock_o), .drv_oe(conversion_clock_oe),
        .pin(conversion_clock_i));
    // ------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic bus(input logic w, input int a, input logic [7:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge mclk);
        avs_address <= a[ADDR_W-1:0];
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h00_0000, d};
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) n_errors++;
    endtask
    // model keeps only the fields the block stores; read-only places ignore writes
    task automatic wr(input int a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        if (avs_byteenable[0]) begin
            case (a)
                3: mdl[3] = d & 8'h31;
                4: mdl[4] = d & 8'h7f;
                6: if (d[0]) mdl = '{default: 8'h00};
                7: mdl[7] = (d[1:0] == 2'h3) ? d & 8'h3c : d & 8'h3f;
                default: ;
            endcase
        end
    endtask
    task automatic rd(input int a);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk("register", q, (a < 8) ? {24'h00_0000, mdl[a]} : 32'h0000_0000);
    endtask
    task automatic rd_all;
        for (int a = 0; a < 8; a++) if (a != 6) rd(a);
        rd(31);
    endtask
    function automatic logic [13:0] exp_code(input logic [13:0] c, input logic dif, sw);
        int v;
        v = $signed(c);
        if (dif && sw) v = -v;
        if (v > 8191) v = 8191;
        if (!dif && v < 0) v = 0;
        return v[13:0];
    endfunction
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        logic [13:0] c, e;
        logic [7:0] f, g;
        logic dif, sw;
        int dv, n;
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        rd(6);
        rd_all();
        chk("gain", amplifier_gain_field, GAIN_X1);
        chk("vref", ref_voltage_sel, REF_2V5);
        avs_byteenable <= 4'h0;
        wr(7, 8'h3f);
        avs_byteenable <= 4'h1;
        wr(0, 8'hff);
        wr(2, 8'hff);
        wr(31, 8'hff);
        rd_all();
        $display("reset and refusal test done");
        for (int i = 0; i < 8; i++) begin
            g = $random(seed);
            if (i < 4) g[1:0] = i[1:0];
            wr(7, {2'h0, g[5:0]});
            rd(7);
            repeat (3) @(posedge mclk);
            chk("vref", ref_voltage_sel, mdl[7][1:0]);
            chk("ref on", ref_en, mdl[7][3]);
            chk("ref clock", ref_clk_from_osc, mdl[7][5] & mdl[7][3]);
            chk("buffer", reference_buffer_oe, mdl[7][2]);
            chk("clock oe", conversion_clock_oe, mdl[7][4]);
            g = $random(seed);
            wr(4, {1'b0, i[2:0], g[3:0]});
            rd(4);
            chk("gain", amplifier_gain_field, i[2:0]);
            chk("channel", analog_inputs_sel, g[3:0]);
        end
        wr(7, 8'h00);
        oscillator_request_pin <= 1'b1;
        repeat (6) @(posedge mclk);
        chk("clock oe", conversion_clock_oe, 1'b1);
        oscillator_request_pin <= 1'b0;
        repeat (6) @(posedge mclk);
        chk("clock oe", conversion_clock_oe, 1'b0);
        $display("configuration test done");
        // run 1 lsb first; last four: saturation, clamp, start pin, oscillator
        for (int i = 0; i < 8; i++) begin
            dv = (i < 4) ? i : 0;
            c = $random(seed);
            f = i[0] ? 8'h00 : $random(seed);
            g = $random(seed);
            dif = $random(seed);
            sw = dif & g[7];
            if (i == 4) {c, dif, sw} = {14'h2000, 2'h3};
            if (i == 5) {c, dif} = {14'h3000, 1'b0};
            wr(3, {2'h0, dv[1:0], 3'h0, i == 1});
            wr(7, (i == 7) ? 8'h10 : 8'h00);
            sar_code <= c;
            fault_detect <= f;
            repeat (4) @(posedge mclk);
            n_edges = 0;
            wr(4, {i != 6, g[2:0], dif, sw, 2'h1});
            convert_pin <= (i == 6);
            n = 0;
            do begin
                @(posedge mclk);
                n++;
            end while (busy !== 1'b1 && n < 20);
            do begin
                @(posedge mclk);
                n++;
            end while (busy !== 1'b0 && n < 25000);
            chk("edges", n_edges >= (50 << dv) && n_edges <= (51 << dv) + 3, 1'b1);
            e = exp_code(c, dif, sw);
            if (i == 1) e = {<<{e}};
            mdl[0] = {e[5:0], 1'b0, |f};
            mdl[1] = e[13:6];
            mdl[2] = f;
            rd(0);
            rd(1);
            rd(2);
            convert_pin <= 1'b0;
            fault_detect <= 8'h00;
            $display("conversion test %0d done", i);
        end
        wr(4, 8'h35);
        reset_pin <= 1'b1;
        repeat (4) @(posedge mclk);
        reset_pin <= 1'b0;
        repeat (4) @(posedge mclk);
        mdl = '{default: 8'h00};
        rd_all();
        wr(7, 8'h2d);
        wr(3, 8'h20);
        wr(6, 8'h01);
        rd_all();
        $display("reset test done");
        give_verdict();
    end
    initial begin
        #800000;
        n_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
